// ==== include/spc_consts.vh ====
`ifndef SPC_CONSTS_VH
`define SPC_CONSTS_VH

// register byte offsets on the wishbone slave
`define SPC_ADR_CTRL 8'h00
`define SPC_ADR_PERIOD 8'h04
`define SPC_ADR_STATUS 8'h08
`define SPC_ADR_STEPS 8'h0c

// ctrl register fields
`define SPC_CTRL_OSC_RUN 0
`define SPC_CTRL_RESET 32'h00000001

// status register field positions
`define SPC_ST_STATE_LSB 0
`define SPC_ST_STATE_MSB 2
`define SPC_ST_HOME 3
`define SPC_ST_PHASE_LSB 4
`define SPC_ST_PHASE_MSB 7
`define SPC_ST_INH_LSB 8
`define SPC_ST_INH_MSB 9
`define SPC_ST_LATCH_LSB 10
`define SPC_ST_LATCH_MSB 11
`define SPC_ST_ENABLE 12

// translator home state and its phase pattern abcd
`define SPC_HOME_STATE 3'h0
`define SPC_HOME_PHASE 4'h5

// timing: clock period and chopper oscillator period
`define SPC_CLK_PERIOD_NS 40
`define SPC_CHOP_PERIOD_NS 50000
`define SPC_CHOP_PERIOD_CYC (`SPC_CHOP_PERIOD_NS / `SPC_CLK_PERIOD_NS)
`define SPC_SYNC_HIGH_NS 80
`define SPC_SYNC_HIGH_CYC (`SPC_SYNC_HIGH_NS / `SPC_CLK_PERIOD_NS)

// reset levels of the synchroniser stages (step clock and reset pin idle high)
`define SPC_PIN_RESET 9'h101

`endif

// ==== logic/spc_sync2.v ====
`timescale 1ns/1ps
module spc_sync2 #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
)(
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // pins in, synchronised levels out
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      reg meta_ff;
      reg sync_ff;
      // two flops; the first is read by the second only
      always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          meta_ff <= RESET_VAL[gi];
          sync_ff <= RESET_VAL[gi];
        end else begin
          meta_ff <= async_i[gi];
          sync_ff <= meta_ff;
        end
      end
      assign sync_o[gi] = sync_ff;
    end
  endgenerate

endmodule // spc_sync2

// ==== logic/spc_translator_chopper.v ====
// Functional notes
// R1: each rising step clock edge advances the translator exactly one increment.
// R2: active-low reset pin returns translator to state 1, phases abcd 0101.
// R3: open-collector home output released (transistor off) while in state 1.
// R4: step size input high selects half step, low selects full step.
// R5: full step from odd state gives two-phase-on drive.
// R6: full step from even state gives one-phase-on wave drive.
// R7: enable low forces both inhibits and all four phases low.
// R8: chopper target input low chops inhibits, high chops phase lines.
// R9: first inhibit gates a/b, drops when de-energised, carries chopping.
// R10: second inhibit gates c/d with the same duties as the first.
// R11: direction input synchronised so it may change at any moment.
// R12: sync line outputs oscillator pulses or accepts an injected clock.
// R13: system grounds oscillator on all but one linked device.
// R14: oscillator pulse sets winding latch; sense trip clears it till next pulse.
// R15: phase chopping activates the non-active line of each pair.
// R16: two-phase-on drive keeps both inhibits high apart from chopping.
// R17: eight-state cyclic counter, one step half, two steps full, up for cw.
// R18: conventional half-step pattern from 0101; even states drop idle inhibit.
`timescale 1ns/1ps
`include "spc_consts.vh"
module spc_translator_chopper #(
  parameter PERIOD_W = 16
)(
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // host step interface pins
  input wire step_clock_i,
  input wire rotation_sense_i,
  input wire half_step_i,
  input wire chip_enable_i,
  input wire chop_target_i,
  input wire translator_reset_n_i,
  // current sense comparator levels
  input wire current_sense_first_i,
  input wire current_sense_second_i,
  // shared chopper sync line, split
  input wire sync_i,
  output wire sync_o,
  output wire sync_oe_o,
  // power bridge drive
  output wire phase_a_o,
  output wire phase_b_o,
  output wire phase_c_o,
  output wire phase_d_o,
  output wire inhibit_first_pair_n_o,
  output wire inhibit_second_pair_n_o,
  // open-collector home indicator, split
  output wire home_o,
  output wire home_oe_o,
  // classic wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o
);

  // synchroniser bit positions
  localparam PIN_STEP = 0;
  localparam PIN_DIR = 1;
  localparam PIN_HALF = 2;
  localparam PIN_EN = 3;
  localparam PIN_TGT = 4;
  localparam PIN_CURRENT_SENSE_FIRST = 5;
  localparam PIN_CURRENT_SENSE_SECOND = 6;
  localparam PIN_SYNC = 7;
  localparam PIN_TRST = 8;

  localparam [31:0] PERIOD_RST32 = `SPC_CHOP_PERIOD_CYC;
  localparam [PERIOD_W-1:0] PERIOD_RST = PERIOD_RST32[PERIOD_W-1:0];
  localparam [31:0] SYNC_HI32 = `SPC_SYNC_HIGH_CYC;
  localparam [PERIOD_W-1:0] SYNC_HI = SYNC_HI32[PERIOD_W-1:0];
  localparam [31:0] CTRL_RST32 = `SPC_CTRL_RESET;

  // phase pattern {a,b,c,d} for each of the eight states
  function [3:0] spc_phase;
    input [2:0] st;
    begin
      case (st)
        3'h0: spc_phase = `SPC_HOME_PHASE;
        3'h1: spc_phase = 4'h1;
        3'h2: spc_phase = 4'h9;
        3'h3: spc_phase = 4'h8;
        3'h4: spc_phase = 4'ha;
        3'h5: spc_phase = 4'h2;
        3'h6: spc_phase = 4'h6;
        default: spc_phase = 4'h4;
      endcase
    end
  endfunction

  // one winding pair under phase chopping
  function [1:0] spc_chop_pair;
    input [1:0] pair;
    input latch;
    input tgt;
    begin
      // R15: brake by raising the idle line
      if (tgt && !latch && (pair != 2'b00)) begin
        spc_chop_pair = 2'b11;
      end else begin
        spc_chop_pair = pair;
      end
    end
  endfunction

  wire [8:0] pin_async;
  wire [8:0] pin_s;

  assign pin_async = {translator_reset_n_i, sync_i, current_sense_second_i,
                      current_sense_first_i, chop_target_i, chip_enable_i,
                      half_step_i, rotation_sense_i, step_clock_i};

  // R11: every pin, direction included, goes through two flops
  spc_sync2 #(
    .WIDTH(9),
    .RESET_VAL(`SPC_PIN_RESET)
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i(pin_async),
    .sync_o(pin_s)
  );

  reg step_prev_ff;
  reg sync_prev_ff;
  reg [2:0] state_ff;
  reg [31:0] steps_ff;
  reg [1:0] latch_ff;
  reg [PERIOD_W-1:0] cnt_ff;
  reg [PERIOD_W-1:0] period_ff;
  reg osc_run_ff;
  reg sync_out_ff;
  reg [3:0] phase_ff;
  reg [1:0] inh_ff;
  reg home_ff;
  reg ack_ff;
  reg [31:0] dat_ff;

  wire step_rise;
  wire sync_rise;
  wire osc_tick;
  wire osc_pulse;
  wire [2:0] step_delta;
  wire [2:0] nxt_state;
  wire [PERIOD_W:0] cnt_inc;
  wire [3:0] pat;
  wire [1:0] sense;
  wire tgt;
  wire [1:0] nxt_ab;
  wire [1:0] nxt_cd;
  wire [1:0] nxt_inh;
  wire bus_req;
  wire bus_wr;
  wire [1:0] nxt_latch;

  // edge detectors read the second synchroniser stage only
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      step_prev_ff <= 1'b1;
      sync_prev_ff <= 1'b0;
    end else begin
      step_prev_ff <= pin_s[PIN_STEP];
      sync_prev_ff <= pin_s[PIN_SYNC];
    end
  end

  // R1: low-to-high transition of the step clock
  assign step_rise = pin_s[PIN_STEP] & ~step_prev_ff;
  assign sync_rise = pin_s[PIN_SYNC] & ~sync_prev_ff;

  // R4: half step moves one state, full step two
  assign step_delta = pin_s[PIN_HALF] ? 3'h1 : 3'h2;
  // R17: up for clockwise, down for anticlockwise, wraps at eight
  assign nxt_state = pin_s[PIN_DIR] ? (state_ff + step_delta) : (state_ff - step_delta);

  // translator; parity is kept in full step, so odd vs even picks the drive
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= `SPC_HOME_STATE;
      steps_ff <= 32'h00000000;
    end else if (!pin_s[PIN_TRST]) begin
      // R2: held at home while the reset pin is low
      state_ff <= `SPC_HOME_STATE;
    end else if (step_rise) begin
      // R5: odd states stay odd in full step, two phases on
      // R6: even states stay even in full step, wave drive
      state_ff <= nxt_state;
      steps_ff <= steps_ff + 32'h00000001;
    end
  end

  // internal chopper oscillator replaces the rc network
  assign cnt_inc = {1'b0, cnt_ff} + {{PERIOD_W{1'b0}}, 1'b1};
  assign osc_tick = osc_run_ff & (cnt_inc >= {1'b0, period_ff});

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= {PERIOD_W{1'b0}};
      sync_out_ff <= 1'b0;
    end else if (!osc_run_ff) begin
      cnt_ff <= {PERIOD_W{1'b0}};
      sync_out_ff <= 1'b0;
    end else begin
      cnt_ff <= osc_tick ? {PERIOD_W{1'b0}} : cnt_inc[PERIOD_W-1:0];
      // only a wrap starts the pulse, so a counter restart never gives a runt
      sync_out_ff <= osc_tick | (sync_out_ff & (cnt_inc[PERIOD_W-1:0] < SYNC_HI));
    end
  end

  // R12: drive the line with our pulses, or chop from whoever drives it
  assign osc_pulse = osc_run_ff ? osc_tick : sync_rise;
  assign sync_o = sync_out_ff;
  assign sync_oe_o = osc_run_ff;

  assign sense = {pin_s[PIN_CURRENT_SENSE_SECOND], pin_s[PIN_CURRENT_SENSE_FIRST]};

  genvar gw;
  generate
    for (gw = 0; gw < 2; gw = gw + 1) begin : g_latch
      // R14: pulse sets, sense trip clears and wins
      assign nxt_latch[gw] = sense[gw] ? 1'b0 : (osc_pulse ? 1'b1 : latch_ff[gw]);
    end
  endgenerate

  // one register for both latches keeps a single driver
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_ff <= 2'h3;
    end else begin
      latch_ff <= nxt_latch;
    end
  end

  // R18: pattern lookup from the translator state
  assign pat = spc_phase(state_ff);
  assign tgt = pin_s[PIN_TGT];

  // R8: high target steers chopping onto the phase pairs
  assign nxt_ab = spc_chop_pair(pat[3:2], latch_ff[0], tgt);
  assign nxt_cd = spc_chop_pair(pat[1:0], latch_ff[1], tgt);

  // R9: first inhibit low when a/b idle, or chopped when target low
  // R10: second inhibit does the same for c/d
  // R16: both pairs energised in two-phase-on, so both stay high
  assign nxt_inh[0] = (|pat[3:2]) & (tgt | latch_ff[0]);
  assign nxt_inh[1] = (|pat[1:0]) & (tgt | latch_ff[1]);

  // registered bridge drive; one cycle behind the translator
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_ff <= 4'h0;
      inh_ff <= 2'h0;
      home_ff <= 1'b1;
    end else begin
      // R3: home flag tracks state 1
      home_ff <= (state_ff == `SPC_HOME_STATE);
      if (!pin_s[PIN_EN]) begin
        // R7: disabled bridge, everything low
        phase_ff <= 4'h0;
        inh_ff <= 2'h0;
      end else begin
        phase_ff <= {nxt_ab, nxt_cd};
        inh_ff <= nxt_inh;
      end
    end
  end

  assign phase_a_o = phase_ff[3];
  assign phase_b_o = phase_ff[2];
  assign phase_c_o = phase_ff[1];
  assign phase_d_o = phase_ff[0];
  assign inhibit_first_pair_n_o = inh_ff[0];
  assign inhibit_second_pair_n_o = inh_ff[1];

  // R3: transistor off (released) when home is active
  assign home_o = 1'b0;
  assign home_oe_o = ~home_ff;

  // wishbone: ack one cycle after the request, write at the acked edge
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_wr = bus_req & ack_ff & wb_we_i;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h00000000;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
      if (bus_req && !ack_ff) begin
        if (wb_adr_i == `SPC_ADR_CTRL) begin
          dat_ff <= {31'h00000000, osc_run_ff};
        end else if (wb_adr_i == `SPC_ADR_PERIOD) begin
          dat_ff <= {{(32-PERIOD_W){1'b0}}, period_ff};
        end else if (wb_adr_i == `SPC_ADR_STATUS) begin
          dat_ff <= {19'h00000, pin_s[PIN_EN], latch_ff, inh_ff, phase_ff,
                     home_ff, state_ff};
        end else if (wb_adr_i == `SPC_ADR_STEPS) begin
          dat_ff <= steps_ff;
        end else begin
          // unmapped: acked, reads zero
          dat_ff <= 32'h00000000;
        end
      end
    end
  end

  // writable registers; status and step count are read-only
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_run_ff <= CTRL_RST32[`SPC_CTRL_OSC_RUN];
      period_ff <= PERIOD_RST;
    end else if (bus_wr) begin
      if (wb_adr_i == `SPC_ADR_CTRL) begin
        if (wb_sel_i[0]) begin
          osc_run_ff <= wb_dat_i[`SPC_CTRL_OSC_RUN];
        end
      end else if (wb_adr_i == `SPC_ADR_PERIOD) begin
        if (wb_sel_i[0]) begin
          period_ff[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          period_ff[PERIOD_W-1:8] <= wb_dat_i[PERIOD_W-1:8];
        end
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

endmodule // spc_translator_chopper

// ==== verif/spc_host_model.sv ====
`timescale 1ns/1ps
module spc_host_model (
  // clock
  input wire logic clk_i,
  // step pins toward the translator
  output logic step_o,
  output logic dir_o,
  output logic half_o,
  output logic trst_n_o
);
  // idle levels: step clock high, reset released
  initial begin
    step_o = 1'b1;
    dir_o = 1'b1;
    half_o = 1'b1;
    trst_n_o = 1'b1;
  end
  task step;
    @(posedge clk_i);
    step_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    step_o <= 1'b1;
    repeat (6) @(posedge clk_i);
    #1;
  endtask
  task mode(input logic d, input logic h);
    @(posedge clk_i);
    dir_o <= d;
    half_o <= h;
  endtask
  // translator reset level
  task trst(input logic v);
    @(posedge clk_i);
    trst_n_o <= v;
  endtask
endmodule // spc_host_model

// ==== verif/spc_checker_sva.sv ====
`timescale 1ns/1ps
module spc_checker_sva (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // control pins
  input wire chip_enable_i,
  input wire chop_target_i,
  input wire translator_reset_n_i,
  input wire current_sense_first_i,
  // bus handshake
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  // drive outputs
  input wire phase_a_o,
  input wire phase_b_o,
  input wire phase_c_o,
  input wire phase_d_o,
  input wire inhibit_first_pair_n_o,
  input wire inhibit_second_pair_n_o,
  input wire home_oe_o,
  input wire sync_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // sense held long enough to pass the synchroniser
  sequence sense_hold;
    (current_sense_first_i && !chop_target_i && chip_enable_i) [*5];
  endsequence
  // sync pulse lasts two cycles
  sequence sync_two;
    sync_o ##1 !sync_o;
  endsequence
  enable_off_a: assert property (
    !chip_enable_i [*5] |-> !(phase_a_o | phase_b_o | phase_c_o | phase_d_o
    | inhibit_first_pair_n_o | inhibit_second_pair_n_o)) else $error("drive on while off");
  ack_next_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  ack_once_a: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_cause_a: assert property (
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  reset_home_a: assert property (
    !translator_reset_n_i [*5] |-> !home_oe_o) else $error("not home in reset");
  idle_first_a: assert property (
    !phase_a_o && !phase_b_o |-> !inhibit_first_pair_n_o) else $error("first inhibit high");
  idle_second_a: assert property (
    !phase_c_o && !phase_d_o |-> !inhibit_second_pair_n_o) else $error("second inhibit high");
  pair_chop_a: assert property (
    phase_a_o && phase_b_o |-> inhibit_first_pair_n_o) else $error("pair chop dropped inhibit");
  sense_chop_a: assert property (
    sense_hold |-> !inhibit_first_pair_n_o) else $error("sense trip ignored");
  sync_pulse_a: assert property (
    $rose(sync_o) |=> sync_two) else $error("sync pulse width");
endmodule // spc_checker_sva
bind spc_translator_chopper spc_checker_sva i_spc_checker_sva (.*);

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic clk_i, rst_n_i, chip_enable_i, chop_target_i, ext_sync;
  logic current_sense_first_i, current_sense_second_i, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, q;
  wire step_clock_i, rotation_sense_i, half_step_i, translator_reset_n_i, sync_i;
  wire sync_o, sync_oe_o, phase_a_o, phase_b_o, phase_c_o, phase_d_o, home_o, home_oe_o;
  wire inhibit_first_pair_n_o, inhibit_second_pair_n_o, wb_ack_o;
  wire [31:0] wb_dat_o;
  wire [3:0] ph = {phase_a_o, phase_b_o, phase_c_o, phase_d_o};
  wire [1:0] inh = {inhibit_second_pair_n_o, inhibit_first_pair_n_o};
  logic [3:0] pat [8] = '{4'h5, 4'h1, 4'h9, 4'h8, 4'ha, 4'h2, 4'h6, 4'h4};
  int num_errors = 0;
  int cmp_count = 0;
  int s = 0;
  // shared sync line: ours while driving, else the external clock
  assign sync_i = sync_oe_o ? sync_o : ext_sync;
  spc_translator_chopper i_spc_translator_chopper (.*);
  spc_host_model i_spc_host_model (.clk_i(clk_i), .step_o(step_clock_i),
    .dir_o(rotation_sense_i), .half_o(half_step_i), .trst_n_o(translator_reset_n_i));
  // 25 mhz clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task stop_test;
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // classic single cycle; waits for ack under a bound
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task pins(input logic a, input logic b, input logic t);
    @(posedge clk_i);
    current_sense_first_i <= a;
    current_sense_second_i <= b;
    chop_target_i <= t;
  endtask
  task pos;
    chk(ph, pat[s]);
    chk(inh, {|pat[s][1:0], |pat[s][3:2]});
    chk(home_oe_o, s != 0);
  endtask
  // the model index follows every step
  task mv(input int d, input int n);
    repeat (n) begin
      i_spc_host_model.step();
      s = (s + d) & 7;
      pos();
    end
  endtask
  task t_regs;
    wt(6);
    pos();
    wb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h1f58);
    chk(home_o, 1'b0);
    wb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h0);
    $display("test home done");
  endtask
  task t_steps;
    i_spc_host_model.mode(1'b1, 1'b1);
    mv(1, 8);
    i_spc_host_model.mode(1'b1, 1'b0);
    mv(2, 4);
    i_spc_host_model.mode(1'b1, 1'b1);
    mv(1, 1);
    i_spc_host_model.mode(1'b1, 1'b0);
    mv(2, 4);
    i_spc_host_model.mode(1'b0, 1'b1);
    mv(-1, 1);
    i_spc_host_model.mode(1'b0, 1'b0);
    mv(-2, 4);
    wb(1'b0, 8'h0c, 32'h0);
    chk(q, 32'h16);
    $display("test steps done");
  endtask
  task t_chop;
    wb(1'b1, 8'h04, 32'h8);
    pins(1'b1, 1'b0, 1'b0);
    wt(8);
    chk(inh, 2'b10);
    pins(1'b0, 1'b1, 1'b0);
    wt(14);
    chk(inh, 2'b01);
    pins(1'b1, 1'b1, 1'b1);
    wt(8);
    chk(ph, 4'hf);
    chk(inh, 2'b11);
    pins(1'b0, 1'b0, 1'b0);
    wt(14);
    pos();
    $display("test chop done");
  endtask
  // oscillator grounded: chopping only from the external sync clock
  task t_sync;
    chk(sync_oe_o, 1'b1);
    wb(1'b1, 8'h00, 32'h0);
    wt(1);
    chk(sync_oe_o, 1'b0);
    pins(1'b1, 1'b0, 1'b0);
    wt(6);
    pins(1'b0, 1'b0, 1'b0);
    wt(20);
    chk(inh, 2'b10);
    @(posedge clk_i);
    ext_sync <= 1'b1;
    wt(8);
    chk(inh, 2'b11);
    @(posedge clk_i);
    ext_sync <= 1'b0;
    wb(1'b1, 8'h00, 32'h1);
    $display("test sync done");
  endtask
  task t_misc;
    @(posedge clk_i);
    chip_enable_i <= 1'b0;
    wt(6);
    chk({ph, inh}, 6'h0);
    @(posedge clk_i);
    chip_enable_i <= 1'b1;
    i_spc_host_model.mode(1'b1, 1'b1);
    mv(1, 3);
    i_spc_host_model.trst(1'b0);
    wt(6);
    s = 0;
    pos();
    i_spc_host_model.step();
    pos();
    i_spc_host_model.trst(1'b1);
    $display("test enable and reset done");
  endtask
  // watchdog well beyond the expected run
  initial begin
    #300000;
    num_errors++;
    stop_test;
  end
  // main sequence
  initial begin
    rst_n_i = 1'b0;
    chip_enable_i = 1'b1;
    chop_target_i = 1'b0;
    ext_sync = 1'b0;
    current_sense_first_i = 1'b0;
    current_sense_second_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_regs;
    t_steps;
    t_chop;
    t_sync;
    t_misc;
    stop_test;
  end
endmodule // tb_top
